// ===== src/pirq_port_irq.v
/*
  Edge-triggered input interrupts for two 8-pin key ports with a debounce
  filter per four-pin group, plus the register slave for their control.
  Assumes asynchronous pin inputs, a 200 MHz clock and a simple strobe bus.
*/
`timescale 1ns/1ps
`include "pirq_defs.vh"

module pirq_port_irq #(
  parameter PINS = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [`PIRQ_ADDR_W-1:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  input wire [PINS-1:0] port0_pin,
  input wire [PINS-1:0] port1_pin,
  output reg port0_irq,
  output reg port1_irq
);

  reg [PINS-1:0] p0_sync1_q;
  reg [PINS-1:0] p0_sync2_q;
  reg [PINS-1:0] p1_sync1_q;
  reg [PINS-1:0] p1_sync2_q;
  reg [PINS-1:0] p0_enable_q;
  reg [PINS-1:0] p1_enable_q;
  reg [PINS-1:0] port0_irq_edge_select_q;
  reg [PINS-1:0] port1_irq_edge_select_q;
  reg [PINS-1:0] p0_flags_q;
  reg [PINS-1:0] p1_flags_q;
  reg [7:0] p0_debounce_q;
  reg [7:0] p1_debounce_q;
  reg [PINS-1:0] p0_prev_q;
  reg [PINS-1:0] p1_prev_q;
  reg [`PIRQ_TICK_W-1:0] prescale_q;
  reg [`PIRQ_SCALER_W-1:0] tick_count_q;
  reg tick_q;
  wire [PINS-1:0] p0_filt;
  wire [PINS-1:0] p1_filt;
  wire [PINS-1:0] p0_event;
  wire [PINS-1:0] p1_event;
  wire [PINS-1:0] p0_flags_d;
  wire [PINS-1:0] p1_flags_d;

  function [PINS-1:0] edge_hit;
    input [PINS-1:0] now;
    input [PINS-1:0] prev;
    input [PINS-1:0] falling;
    begin
      edge_hit = (falling & prev & ~now) | (~falling & ~prev & now);
    end
  endfunction

  function write_hit;
    input [`PIRQ_ADDR_W-1:0] addr;
    input [`PIRQ_ADDR_W-1:0] target;
    input wr;
    begin
      write_hit = wr & (addr == target);
    end
  endfunction

  // Two-stage synchronisers for the pin inputs
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      p0_sync1_q <= {PINS{1'b0}};
      p0_sync2_q <= {PINS{1'b0}};
      p1_sync1_q <= {PINS{1'b0}};
      p1_sync2_q <= {PINS{1'b0}};
    end
    else
    begin
      p0_sync1_q <= port0_pin;
      p0_sync2_q <= p0_sync1_q;
      p1_sync1_q <= port1_pin;
      p1_sync2_q <= p1_sync1_q;
    end
  end

  // One shared base tick of 256 periods; longer check times count ticks
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      prescale_q <= 8'h00;
      tick_count_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      prescale_q <= prescale_q + 8'h01;
      tick_q <= (prescale_q == 8'hff);
      if (tick_q)
        tick_count_q <= tick_count_q + 7'h01;
    end
  end

  pirq_filter #(.WIDTH(4)) u_p0_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .tick_count(tick_count_q),
    .time_code(p0_debounce_q[2:0]),
    .pin_in(p0_sync2_q[3:0]),
    .pin_out(p0_filt[3:0])
  );

  pirq_filter #(.WIDTH(4)) u_p0_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .tick_count(tick_count_q),
    .time_code(p0_debounce_q[6:4]),
    .pin_in(p0_sync2_q[7:4]),
    .pin_out(p0_filt[7:4])
  );

  pirq_filter #(.WIDTH(4)) u_p1_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .tick_count(tick_count_q),
    .time_code(p1_debounce_q[2:0]),
    .pin_in(p1_sync2_q[3:0]),
    .pin_out(p1_filt[3:0])
  );

  pirq_filter #(.WIDTH(4)) u_p1_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick_q),
    .tick_count(tick_count_q),
    .time_code(p1_debounce_q[6:4]),
    .pin_in(p1_sync2_q[7:4]),
    .pin_out(p1_filt[7:4])
  );

  // Previous filtered level; reset to zero like the filter, so a pin held
  // high through reset still gives a rising edge just after reset
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      p0_prev_q <= {PINS{1'b0}};
      p1_prev_q <= {PINS{1'b0}};
    end
    else
    begin
      p0_prev_q <= p0_filt;
      p1_prev_q <= p1_filt;
    end
  end

  assign p0_event = edge_hit(p0_filt, p0_prev_q, port0_irq_edge_select_q);
  assign p1_event = edge_hit(p1_filt, p1_prev_q, port1_irq_edge_select_q);

  // New edge wins over a clear in the same cycle
  assign p0_flags_d = p0_event |
    (p0_flags_q & ~(write_hit(bus_addr, `PIRQ_P0_IRQ_FLAGS, bus_wr) ? bus_wdata : 8'h00));
  assign p1_flags_d = p1_event |
    (p1_flags_q & ~(write_hit(bus_addr, `PIRQ_P1_IRQ_FLAGS, bus_wr) ? bus_wdata : 8'h00));

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      p0_enable_q <= `PIRQ_RST_ENABLE;
      p1_enable_q <= `PIRQ_RST_ENABLE;
      port0_irq_edge_select_q <= `PIRQ_RST_EDGE;
      port1_irq_edge_select_q <= `PIRQ_RST_EDGE;
      p0_flags_q <= `PIRQ_RST_FLAGS;
      p1_flags_q <= `PIRQ_RST_FLAGS;
      p0_debounce_q <= `PIRQ_RST_DEBOUNCE;
      p1_debounce_q <= `PIRQ_RST_DEBOUNCE;
    end
    else
    begin
      p0_flags_q <= p0_flags_d;
      p1_flags_q <= p1_flags_d;
      if (write_hit(bus_addr, `PIRQ_P0_IRQ_ENABLE, bus_wr))
        p0_enable_q <= bus_wdata;
      if (write_hit(bus_addr, `PIRQ_P1_IRQ_ENABLE, bus_wr))
        p1_enable_q <= bus_wdata;
      if (write_hit(bus_addr, `PIRQ_P0_IRQ_EDGE_SELECT, bus_wr))
        port0_irq_edge_select_q <= bus_wdata;
      if (write_hit(bus_addr, `PIRQ_P1_IRQ_EDGE_SELECT, bus_wr))
        port1_irq_edge_select_q <= bus_wdata;
      if (write_hit(bus_addr, `PIRQ_P0_DEBOUNCE_CTRL, bus_wr))
        p0_debounce_q <= bus_wdata & `PIRQ_DEBOUNCE_MASK;
      if (write_hit(bus_addr, `PIRQ_P1_DEBOUNCE_CTRL, bus_wr))
        p1_debounce_q <= bus_wdata & `PIRQ_DEBOUNCE_MASK;
    end
  end

  // Requests go out registered, together with the flag they follow;
  // port 0 feeds vector 4 and port 1 vector 5 at the controller
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      port0_irq <= 1'b0;
      port1_irq <= 1'b0;
    end
    else
    begin
      port0_irq <= |(p0_flags_d & p0_enable_q);
      port1_irq <= |(p1_flags_d & p1_enable_q);
    end
  end

  // Read data one cycle after the strobe, zero otherwise and when unmapped
  always @(posedge clk)
  begin
    if (sys_rst)
      bus_rdata <= 8'h00;
    else if (bus_rd)
    begin
      case (bus_addr)
        `PIRQ_P0_IRQ_ENABLE: bus_rdata <= p0_enable_q;
        `PIRQ_P0_IRQ_EDGE_SELECT: bus_rdata <= port0_irq_edge_select_q;
        `PIRQ_P0_IRQ_FLAGS: bus_rdata <= p0_flags_q;
        `PIRQ_P0_DEBOUNCE_CTRL: bus_rdata <= p0_debounce_q;
        `PIRQ_P1_IRQ_ENABLE: bus_rdata <= p1_enable_q;
        `PIRQ_P1_IRQ_EDGE_SELECT: bus_rdata <= port1_irq_edge_select_q;
        `PIRQ_P1_IRQ_FLAGS: bus_rdata <= p1_flags_q;
        `PIRQ_P1_DEBOUNCE_CTRL: bus_rdata <= p1_debounce_q;
        default: bus_rdata <= 8'h00;
      endcase
    end
    else
      bus_rdata <= 8'h00;
  end

endmodule // pirq_port_irq

// ===== common/pirq_defs.vh
/*
  Constants for the port input interrupt block: register offsets, field
  positions, reset values and filter timing.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef PIRQ_DEFS_VH
`define PIRQ_DEFS_VH

`define PIRQ_ADDR_W 16
`define PIRQ_P0_IRQ_ENABLE 16'h5205
`define PIRQ_P0_IRQ_EDGE_SELECT 16'h5206
`define PIRQ_P0_IRQ_FLAGS 16'h5207
`define PIRQ_P0_DEBOUNCE_CTRL 16'h5208
`define PIRQ_P1_IRQ_ENABLE 16'h5215
`define PIRQ_P1_IRQ_EDGE_SELECT 16'h5216
`define PIRQ_P1_IRQ_FLAGS 16'h5217
`define PIRQ_P1_DEBOUNCE_CTRL 16'h5218

`define PIRQ_LOW_TIME_LSB 0
`define PIRQ_HIGH_TIME_LSB 4
`define PIRQ_TIME_W 3
`define PIRQ_DEBOUNCE_MASK 8'h77

`define PIRQ_RST_ENABLE 8'h00
`define PIRQ_RST_EDGE 8'h00
`define PIRQ_RST_FLAGS 8'h00
`define PIRQ_RST_DEBOUNCE 8'h00

`define PIRQ_TICK_PERIODS 256
`define PIRQ_TICK_W 8
`define PIRQ_SCALER_W 7

`endif

// ===== src/pirq_filter.v
/*
  Debounce filter for one group of four pins sharing a check time.
  Assumes synchronised inputs and a common tick every 256 clock periods.
*/
`timescale 1ns/1ps
`include "pirq_defs.vh"

module pirq_filter #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire tick,
  input wire [`PIRQ_SCALER_W-1:0] tick_count,
  input wire [`PIRQ_TIME_W-1:0] time_code,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] sample_q;
  reg sample_en;

  // A sample is taken once per check time; code 1 samples on every tick
  always @*
  begin
    case (time_code)
      3'h1: sample_en = tick;
      3'h2: sample_en = tick & (tick_count[0] == 1'b1);
      3'h3: sample_en = tick & (tick_count[1:0] == 2'h3);
      3'h4: sample_en = tick & (tick_count[2:0] == 3'h7);
      3'h5: sample_en = tick & (tick_count[3:0] == 4'hf);
      3'h6: sample_en = tick & (tick_count[4:0] == 5'h1f);
      3'h7: sample_en = tick & (tick_count[5:0] == 6'h3f);
      default: sample_en = 1'b0;
    endcase
  end

  // Level accepted when two successive samples agree: it persisted at
  // least one and at most two check times, shorter pulses are dropped.
  // Judged pin by pin, so a bouncing neighbour cannot hold back a steady pin
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sample_q <= {WIDTH{1'b0}};
      pin_out <= {WIDTH{1'b0}};
    end
    else if (time_code == 3'h0)
    begin
      sample_q <= pin_in;
      pin_out <= pin_in;
    end
    else if (sample_en)
    begin
      sample_q <= pin_in;
      pin_out <= (pin_out & (sample_q | pin_in)) | (sample_q & pin_in);
    end
  end

endmodule // pirq_filter

// ===== tb/pirq_irq_properties.sv
/* Assertions on the port interrupt block's top ports.
   Assumes pins stay still while the bench clears flags. */
`timescale 1ns/1ps
`include "pirq_defs.vh"
module pirq_irq_properties #(
  parameter PINS = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [`PIRQ_ADDR_W-1:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire [PINS-1:0] port0_pin,
  input wire [PINS-1:0] port1_pin,
  input wire port0_irq,
  input wire port1_irq
);
  // Shadows of port 0 settings, so edge timing is judged only when it applies
  reg [7:0] en_q;
  reg [7:0] fall_q;
  reg [7:0] deb_q;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      en_q <= 8'h00;
      fall_q <= 8'h00;
      deb_q <= 8'h00;
    end
    else if (bus_wr)
    begin
      if (bus_addr == `PIRQ_P0_IRQ_ENABLE)
        en_q <= bus_wdata;
      if (bus_addr == `PIRQ_P0_IRQ_EDGE_SELECT)
        fall_q <= bus_wdata;
      if (bus_addr == `PIRQ_P0_DEBOUNCE_CTRL)
        deb_q <= bus_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_spare_bits_zero: assert property (
    bus_rd && (bus_addr | 16'h0010) == `PIRQ_P1_DEBOUNCE_CTRL
    |=> bus_rdata[3] == 1'b0 && bus_rdata[7] == 1'b0) else $error("spare bits set");
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !port0_irq && !port1_irq) else $error("request after reset");
  chk_enable_readback: assert property (
    bus_wr && bus_addr == `PIRQ_P0_IRQ_ENABLE ##1 bus_rd && bus_addr == `PIRQ_P0_IRQ_ENABLE
    |=> bus_rdata == $past(bus_wdata, 2)) else $error("enable readback wrong");
  chk_edge_readback: assert property (
    bus_wr && bus_addr == `PIRQ_P0_IRQ_EDGE_SELECT
    ##1 bus_rd && bus_addr == `PIRQ_P0_IRQ_EDGE_SELECT
    |=> bus_rdata == $past(bus_wdata, 2)) else $error("edge readback wrong");
  chk_disabled_quiet: assert property (
    en_q == 8'h00 && $past(en_q) == 8'h00 |-> !port0_irq) else $error("masked request");
  chk_mask_drops: assert property (
    bus_wr && bus_addr == `PIRQ_P1_IRQ_ENABLE && bus_wdata == 8'h00
    |-> ##2 !port1_irq) else $error("request kept after mask");
  chk_clear_drops: assert property (
    bus_wr && bus_addr == `PIRQ_P0_IRQ_FLAGS && (en_q & ~bus_wdata) == 8'h00
    && deb_q == 8'h00 && $past(port0_pin, 3) == $past(port0_pin, 4)
    |=> !port0_irq) else $error("request kept after clear");
  chk_edge_latency: assert property (
    en_q[0] && deb_q[2:0] == 3'h0
    && (fall_q[0] ? $fell(port0_pin[0]) : $rose(port0_pin[0]))
    |-> ##4 port0_irq) else $error("edge gave no request");
endmodule // pirq_irq_properties

bind pirq_port_irq pirq_irq_properties #(.PINS(PINS)) pirq_irq_properties_i (
  .clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .port0_pin(port0_pin),
  .port1_pin(port1_pin), .port0_irq(port0_irq), .port1_irq(port1_irq));

// ===== tb/pirq_intc_model.sv
/* Interrupt controller model taking the two port requests.
   Assumes level requests on the same clock; zero means none taken. */
`timescale 1ns/1ps
module pirq_intc_model #(
  parameter LEVEL0 = 0,
  parameter LEVEL1 = 0
) (
  input wire clk,
  input wire sys_rst,
  input wire global_ie,
  input wire port0_irq,
  input wire port1_irq,
  output reg [7:0] vector_q
);
  always @(posedge clk)
  begin
    if (sys_rst || !global_ie)
      vector_q <= 8'h00;
    else if (port1_irq && (!port0_irq || LEVEL1 > LEVEL0))
      vector_q <= 8'h05;
    else
      vector_q <= port0_irq ? 8'h04 : 8'h00;
  end
endmodule // pirq_intc_model

// ===== tb/tb_pirq_port_irq.sv
/* Self-checking bench for the port interrupt block and controller model.
   Assumes a 200 MHz clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "pirq_defs.vh"
module tb_pirq_port_irq;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [15:0] addr = 16'h0000;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] p0 = 8'h00;
  reg [7:0] p1 = 8'h00;
  reg ie = 1'b1;
  reg [7:0] v;
  wire [7:0] rdata;
  wire [7:0] vec;
  wire [1:0] irqs;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer n;
  integer k;
  pirq_port_irq #(.PINS(8)) pirq_port_irq_i (.clk(clk), .sys_rst(sys_rst),
    .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
    .port0_pin(p0), .port1_pin(p1), .port0_irq(irqs[0]), .port1_irq(irqs[1]));
  pirq_intc_model pirq_intc_model_i (.clk(clk), .sys_rst(sys_rst), .global_ie(ie),
    .port0_irq(irqs[0]), .port1_irq(irqs[1]), .vector_q(vec));
  task check(input [7:0] seen, input [7:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task rd_reg(input [15:0] a);
  begin
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
  end
  endtask
  // Read straight after the write, so readback is exercised back to back
  task wr_rd(input [15:0] a, input [7:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd_reg(a);
  end
  endtask
  task wait_irq(input integer s, input integer lim);
  begin
    n = 0;
    while (irqs[s] !== 1'b1)
    begin
      if (n >= lim)
      begin
        mismatches = mismatches + 1;
        $display("ERROR %0t request timed out", $time);
        results;
      end
      @(posedge clk);
      #1;
      n = n + 1;
    end
    @(posedge clk);
  end
  endtask
  task t_regs;
  begin
    for (k = 0; k < 9; k = k + 1)
    begin
      rd_reg(16'h5205 + {k[3], 3'h0} + {k[2], 4'h0} + k[1:0]);
      check(v, 8'h00);
    end
    for (k = 0; k < 16; k = k + 1)
    begin
      wr_rd(k[3] ? `PIRQ_P1_DEBOUNCE_CTRL : `PIRQ_P0_DEBOUNCE_CTRL, {2{1'b1, k[2:0]}});
      check(v, {2{1'b0, k[2:0]}});
    end
    wr_rd(`PIRQ_P0_DEBOUNCE_CTRL, 8'h00);
    wr_rd(`PIRQ_P0_IRQ_ENABLE, 8'h5a);
    check(v, 8'h5a);
    $display("t_regs done");
  end
  endtask
  task t_edges;
  begin
    for (k = 0; k < 2; k = k + 1)
    begin
      wr_rd(`PIRQ_P0_IRQ_EDGE_SELECT, k[7:0]);
      p0[0] <= k[0];
      repeat (8) @(posedge clk);
      wr_rd(`PIRQ_P0_IRQ_FLAGS, 8'hff);
      check(v, 8'h00);
      wr_rd(`PIRQ_P0_IRQ_ENABLE, 8'h01);
      p0[0] <= !k[0];
      wait_irq(0, 6);
      check(n[7:0], 8'h04);
      repeat (2) @(posedge clk);
      check(vec, 8'h04);
      wr_rd(`PIRQ_P0_IRQ_FLAGS, 8'h00);
      check({v[5:0], irqs}, 8'h05);
      wr_rd(`PIRQ_P0_IRQ_FLAGS, 8'h01);
      check({v[5:0], irqs}, 8'h00);
      p0[0] <= k[0];
      repeat (8) @(posedge clk);
      rd_reg(`PIRQ_P0_IRQ_FLAGS);
      check(v, 8'h00);
    end
    $display("t_edges done");
  end
  endtask
  task t_filter;
  begin
    wr_rd(`PIRQ_P1_DEBOUNCE_CTRL, 8'h01);
    wr_rd(`PIRQ_P1_IRQ_FLAGS, 8'hff);
    wr_rd(`PIRQ_P1_IRQ_ENABLE, 8'h01);
    p1[0] <= 1'b1;
    repeat (200) @(posedge clk);
    p1[0] <= 1'b0;
    repeat (800) @(posedge clk);
    check({6'h00, irqs}, 8'h00);
    p1[0] <= 1'b1;
    wait_irq(1, 600);
    check({7'h00, n >= 256 && n <= 520}, 8'h01);
    repeat (2) @(posedge clk);
    check(vec, 8'h05);
    ie <= 1'b0;
    repeat (2) @(posedge clk);
    check(vec, 8'h00);
    wr_rd(`PIRQ_P1_IRQ_ENABLE, 8'h00);
    rd_reg(`PIRQ_P1_IRQ_FLAGS);
    check({v[5:0], irqs}, 8'h04);
    wr_rd(`PIRQ_P1_DEBOUNCE_CTRL, 8'h00);
    check(v, 8'h00);
    $display("t_filter done");
  end
  endtask
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_edges;
    t_filter;
    results;
  end
endmodule // tb_pirq_port_irq
